// [verilog/cbr_pkg.sv]
// Constants, field layouts and carrier types for the buffered register map
package cbr_pkg;

  // Number of indexed targets: eight main converters then eight auxiliary functions
  localparam int CBR_NT = 16;
  localparam int CBR_NMAIN = 8;

  // Register offsets
  localparam logic [7:0] CBR_ADDR_ID = 8'h01;
  localparam logic [7:0] CBR_ADDR_GRADE = 8'h02;
  localparam logic [7:0] CBR_ADDR_UPSEL = 8'h04;
  localparam logic [7:0] CBR_ADDR_LOSEL = 8'h05;
  localparam logic [7:0] CBR_ADDR_MODES = 8'h08;
  localparam logic [7:0] CBR_ADDR_CLK = 8'h09;
  localparam logic [7:0] CBR_ADDR_XFER = 8'hff;

  // Transfer register fields
  localparam int CBR_XFER_SW_BIT = 0;
  localparam int CBR_XFER_HW_BIT = 7;

  // Mode register fields
  localparam int CBR_MODE_EXT_EN_BIT = 7;
  localparam int CBR_MODE_EXT_LSB = 5;
  localparam int CBR_MODE_BYP_BIT = 3;
  localparam int CBR_MODE_PWR_LSB = 0;
  localparam logic [7:0] CBR_MODES_MASK = 8'hef;

  // Clock register fields
  localparam int CBR_CLK_PLL_BIT = 2;
  localparam int CBR_CLK_BOOST_BIT = 1;
  localparam int CBR_CLK_DCS_BIT = 0;
  localparam logic [7:0] CBR_CLK_MASK = 8'h07;

  // Values after reset
  localparam logic [7:0] CBR_MODES_RST = 8'h00;
  localparam logic [7:0] CBR_CLK_RST = 8'h01;
  localparam logic [7:0] CBR_LOSEL_RST = 8'h01;
  localparam logic [7:0] CBR_UPSEL_RST = 8'h00;

  // Internal power field codes
  localparam logic [2:0] CBR_PWR_RUN = 3'h0;
  localparam logic [2:0] CBR_PWR_FULL_PD = 3'h1;
  localparam logic [2:0] CBR_PWR_STBY = 3'h2;
  localparam logic [2:0] CBR_PWR_CHIP_RST = 3'h3;
  localparam logic [2:0] CBR_PWR_CORE_PD = 3'h4;
  localparam logic [2:0] CBR_PWR_AFE_PD = 3'h5;

  // External pin mode field codes
  localparam logic [1:0] CBR_EXT_FULL_PD = 2'h0;
  localparam logic [1:0] CBR_EXT_STBY = 2'h1;
  localparam logic [1:0] CBR_EXT_DOUT = 2'h3;

  // Register access from the serial state machine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cbr_bus_t;

  // Decoded controls for one target
  typedef struct packed {
    logic full_pd;
    logic standby;
    logic core_pd;
    logic afe_pd;
    logic bypass;
    logic dout_en;
    logic pll_en;
    logic clk_boost;
    logic duty_cycle_stabilizer;
  } cbr_ctl_t;

  // Transfer sequencer states
  typedef enum logic [1:0] {
    CBR_XF_IDLE = 2'b01,
    CBR_XF_PULSE = 2'b10
  } cbr_xf_t;

endpackage

// [verilog/cbr_regmap.sv]
// Buffered register map with transfer control, indexing and mode decode
`timescale 1ns/100ps

// What this block does
// [RULE1] Config, both index and transfer registers are never master/slave buffered.
// [RULE2] Buffered writes land in the master; slave changes only on a transfer or when the chip reset code returns its power field to run.
// [RULE3] Unbuffered registers take a written value at once.
// [RULE4] Software transfer bit fires one transfer strobe, then clears itself.
// [RULE5] Masters keep written values until rewritten, except the mode power field on the chip reset code, ready for a broadcast transfer.
// [RULE6] Hardware-transfer enable clear: software trigger; set: external pin trigger.
// [RULE7] Host writes all other registers first, transfer command last.
// [RULE8] Die identifier register is read-only and fixed at design time.
// [RULE9] Lower index selects converters 0-3, upper index converters 4-7.
// [RULE10] Index upper nibble enables auxiliary functions, lower nibble main converters.
// [RULE11] One write reaches every target whose enable bit is set.
// [RULE12] Several targets enabled on read: no contention, returned target undefined.
// [RULE13] Host enables exactly one target before a readback; the bench reads the mode register back once with several targets enabled.
// [RULE14] External enable clear: internal power field sets the operating mode.
// [RULE15] External enable set: pin low applies pin mode field, pin high normal.
// [RULE16] Without a power-down pin, external enable and pin mode field are ignored.
// [RULE17] Pin mode field: 00 power-down, 01 standby, 10 reserved, 11 outputs on.
// [RULE18] Function bypass bit bypasses and powers down analog processing.
// [RULE19] Internal power field decodes run, power-down, standby, reset, core, front end.
// [RULE20] After chip reset code, internal power field returns to run.
// [RULE21] Clock register bit enables the on-chip phase-locked loop.
// [RULE22] Clock boost bit selects low-jitter high-bias or low-power setting.
// [RULE23] Duty cycle stabilizer bit enables it; clock register resets with it on.
// [RULE24] Transfer strobe updates all slave registers in the same cycle.
module cbr_regmap #(
  parameter bit HAS_PDWN_PIN = 1'b1,
  parameter bit HAS_HW_XFER = 1'b1,
  parameter logic [7:0] DIE_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] GRADE_INFO = 8'h00 // Arbitrary value
) (
  input logic clk_sys,
  input logic srst,
  input cbr_pkg::cbr_bus_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input logic xfer_pin,
  input logic pdwn_pin_n,
  output logic xfer_stb_out,
  output logic [cbr_pkg::CBR_NT-1:0] chip_reset_out,
  output cbr_pkg::cbr_ctl_t ctl_out [cbr_pkg::CBR_NT]
);

  localparam int NT = cbr_pkg::CBR_NT;

  logic [7:0] losel_reg;
  logic [7:0] upsel_reg;
  logic hw_en_reg;
  logic sw_flag_reg;
  logic pin_q_reg;
  cbr_pkg::cbr_xf_t xf_state_reg;
  cbr_pkg::cbr_xf_t xf_state_next;
  logic [NT-1:0] sel;
  logic xfer_stb;
  logic hw_trig;
  logic sw_trig;
  logic hw_en_eff;
  logic [7:0] mst_modes [NT];
  logic [7:0] mst_clk [NT];
  logic [7:0] slv_modes [NT];
  logic [7:0] slv_clk [NT];
  logic [7:0] rd_mux;
  logic [7:0] tgt_modes;
  logic [7:0] tgt_clk;

  // Write hits
  logic wr_lo;
  logic wr_up;
  logic wr_xfer;
  logic wr_modes;
  logic wr_clk;
  assign wr_lo = reg_req.wr && (reg_req.addr == cbr_pkg::CBR_ADDR_LOSEL);
  assign wr_up = reg_req.wr && (reg_req.addr == cbr_pkg::CBR_ADDR_UPSEL);
  assign wr_xfer = reg_req.wr && (reg_req.addr == cbr_pkg::CBR_ADDR_XFER);
  assign wr_modes = reg_req.wr && (reg_req.addr == cbr_pkg::CBR_ADDR_MODES);
  assign wr_clk = reg_req.wr && (reg_req.addr == cbr_pkg::CBR_ADDR_CLK);

  // [RULE9] Target enables from index
  // [RULE10] Nibble mapping main/auxiliary
  assign sel = {upsel_reg[7:4], losel_reg[7:4], upsel_reg[3:0], losel_reg[3:0]};

  // Index registers
  // [RULE1] Index registers unbuffered
  // [RULE3] Immediate effect
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      losel_reg <= cbr_pkg::CBR_LOSEL_RST;
      upsel_reg <= cbr_pkg::CBR_UPSEL_RST;
    end else begin
      if (wr_lo) begin
        losel_reg <= reg_req.wdata;
      end
      if (wr_up) begin
        upsel_reg <= reg_req.wdata;
      end
    end
  end

  // Hardware transfer enable, written straight through
  // [RULE1] Transfer register unbuffered
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hw_en_reg <= 1'b0;
    end else if (wr_xfer) begin
      hw_en_reg <= HAS_HW_XFER & reg_req.wdata[cbr_pkg::CBR_XFER_HW_BIT];
    end
  end

  assign hw_en_eff = HAS_HW_XFER & hw_en_reg;

  // Software transfer flag; a new set wins over the self-clear
  // [RULE4] Set then self-clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sw_flag_reg <= 1'b0;
    end else if (wr_xfer && reg_req.wdata[cbr_pkg::CBR_XFER_SW_BIT]) begin
      sw_flag_reg <= 1'b1;
    end else if (xfer_stb) begin
      sw_flag_reg <= 1'b0;
    end
  end

  // Pin history for edge detection
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_q_reg <= 1'b0;
    end else begin
      pin_q_reg <= xfer_pin;
    end
  end

  // [RULE6] Trigger source select
  assign hw_trig = hw_en_eff && xfer_pin && !pin_q_reg;
  assign sw_trig = !hw_en_eff && sw_flag_reg;

  // Transfer sequencer next state
  always_comb begin
    xf_state_next = xf_state_reg;
    case (xf_state_reg)
      cbr_pkg::CBR_XF_IDLE: begin
        if (hw_trig || sw_trig) begin
          xf_state_next = cbr_pkg::CBR_XF_PULSE;
        end
      end
      cbr_pkg::CBR_XF_PULSE: begin
        xf_state_next = cbr_pkg::CBR_XF_IDLE;
      end
      default: begin
        xf_state_next = cbr_pkg::CBR_XF_IDLE;
      end
    endcase
  end

  // Transfer sequencer state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xf_state_reg <= cbr_pkg::CBR_XF_IDLE;
    end else begin
      xf_state_reg <= xf_state_next;
    end
  end

  assign xfer_stb = (xf_state_reg == cbr_pkg::CBR_XF_PULSE);
  assign xfer_stb_out = xf_state_reg[1]; // Strobe is the pulse state bit

  // Per-target master, slave and control decode
  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_tgt
      logic rst_hit;
      logic [1:0] ext_mode;
      logic [2:0] pwr;
      cbr_pkg::cbr_ctl_t ctl_next;

      assign pwr = slv_modes[t][cbr_pkg::CBR_MODE_PWR_LSB +: 3];
      assign ext_mode = slv_modes[t][cbr_pkg::CBR_MODE_EXT_LSB +: 2];
      assign rst_hit = (pwr == cbr_pkg::CBR_PWR_CHIP_RST);

      // Master mode copy; holds until rewritten, except its power field returns to run on the chip reset code
      // [RULE2] Write lands in master
      // [RULE5] Masters retained
      // [RULE11] Write to all enabled targets
      // [RULE20] Run code after reset
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          mst_modes[t] <= cbr_pkg::CBR_MODES_RST;
        end else if (wr_modes && sel[t]) begin
          mst_modes[t] <= reg_req.wdata & cbr_pkg::CBR_MODES_MASK;
        end else if (rst_hit) begin
          mst_modes[t][cbr_pkg::CBR_MODE_PWR_LSB +: 3] <= cbr_pkg::CBR_PWR_RUN;
        end
      end

      // Master clock copy
      // [RULE11] Write to all enabled targets
      // [RULE23] Stabilizer on after reset
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          mst_clk[t] <= cbr_pkg::CBR_CLK_RST;
        end else if (wr_clk && sel[t]) begin
          mst_clk[t] <= reg_req.wdata & cbr_pkg::CBR_CLK_MASK;
        end
      end

      // Slave copies load together on the strobe
      // [RULE2] Slave on transfer only
      // [RULE24] Atomic slave update
      // [RULE20] Run code after reset
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          slv_modes[t] <= cbr_pkg::CBR_MODES_RST;
          slv_clk[t] <= cbr_pkg::CBR_CLK_RST;
        end else if (xfer_stb) begin
          slv_modes[t] <= mst_modes[t];
          slv_clk[t] <= mst_clk[t];
        end else if (rst_hit) begin
          slv_modes[t][cbr_pkg::CBR_MODE_PWR_LSB +: 3] <= cbr_pkg::CBR_PWR_RUN;
        end
      end

      // Control decode from the active copies
      // [RULE14] Internal field rules
      // [RULE15] Pin overrides
      // [RULE16] No pin: ignore
      // [RULE17] Pin mode decode
      // [RULE18] Function bypass
      // [RULE19] Power field decode
      // [RULE21] PLL enable
      // [RULE22] Clock boost
      // [RULE23] Stabilizer enable
      always_comb begin
        ctl_next = '0;
        ctl_next.bypass = slv_modes[t][cbr_pkg::CBR_MODE_BYP_BIT];
        ctl_next.pll_en = slv_clk[t][cbr_pkg::CBR_CLK_PLL_BIT];
        ctl_next.clk_boost = slv_clk[t][cbr_pkg::CBR_CLK_BOOST_BIT];
        ctl_next.duty_cycle_stabilizer = slv_clk[t][cbr_pkg::CBR_CLK_DCS_BIT];
        ctl_next.dout_en = 1'b1;
        if (HAS_PDWN_PIN && slv_modes[t][cbr_pkg::CBR_MODE_EXT_EN_BIT]) begin
          if (!pdwn_pin_n) begin
            case (ext_mode)
              cbr_pkg::CBR_EXT_FULL_PD: begin
                ctl_next.full_pd = 1'b1;
                ctl_next.dout_en = 1'b0;
              end
              cbr_pkg::CBR_EXT_STBY: begin
                ctl_next.standby = 1'b1;
                ctl_next.dout_en = 1'b0;
              end
              default: begin
                ctl_next.dout_en = 1'b1; // Reserved code acts as normal
              end
            endcase
          end
        end else begin
          case (pwr)
            cbr_pkg::CBR_PWR_FULL_PD: begin
              ctl_next.full_pd = 1'b1;
              ctl_next.dout_en = 1'b0;
            end
            cbr_pkg::CBR_PWR_STBY: begin
              ctl_next.standby = 1'b1;
              ctl_next.dout_en = 1'b0;
            end
            cbr_pkg::CBR_PWR_CORE_PD: begin
              ctl_next.core_pd = 1'b1;
            end
            cbr_pkg::CBR_PWR_AFE_PD: begin
              ctl_next.afe_pd = 1'b1;
            end
            default: begin
              ctl_next.dout_en = 1'b1; // Run, reset and reserved codes
            end
          endcase
        end
      end

      // Registered controls and reset pulse
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          ctl_out[t] <= '0;
          chip_reset_out[t] <= 1'b0;
        end else begin
          ctl_out[t] <= ctl_next;
          chip_reset_out[t] <= rst_hit;
        end
      end
    end
  endgenerate

  // Lowest enabled target drives the readback path
  // [RULE12] Priority select avoids contention
  always_comb begin
    tgt_modes = '0;
    tgt_clk = '0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (sel[i]) begin
        tgt_modes = mst_modes[i];
        tgt_clk = mst_clk[i];
      end
    end
  end

  // Read data mux; unmapped offsets read zero
  // [RULE8] Fixed identifier
  always_comb begin
    case (reg_req.addr)
      cbr_pkg::CBR_ADDR_ID: rd_mux = DIE_ID;
      cbr_pkg::CBR_ADDR_GRADE: rd_mux = GRADE_INFO;
      cbr_pkg::CBR_ADDR_UPSEL: rd_mux = upsel_reg;
      cbr_pkg::CBR_ADDR_LOSEL: rd_mux = losel_reg;
      cbr_pkg::CBR_ADDR_MODES: rd_mux = tgt_modes;
      cbr_pkg::CBR_ADDR_CLK: rd_mux = tgt_clk;
      cbr_pkg::CBR_ADDR_XFER: rd_mux = {hw_en_reg, 6'h00, sw_flag_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  a_sw_xfer_fire: assert property ( // [RULE4]
    wr_xfer && reg_req.wdata[0] && !hw_en_eff && !reg_req.wdata[7] |-> ##[1:2] xfer_stb_out)
    else $error("software transfer did not strobe");

  a_sw_flag_clear: assert property ( // [RULE4]
    xfer_stb_out && !(wr_xfer && reg_req.wdata[0]) |=> !sw_flag_reg)
    else $error("transfer flag not cleared");

  a_hw_pin_gate: assert property ( // [RULE6]
    !hw_en_eff && !sw_flag_reg && xfer_pin && !pin_q_reg && !xfer_stb |=> !xfer_stb_out)
    else $error("pin triggered transfer while disabled");

  a_slave_load: assert property ( // [RULE24]
    xfer_stb |=> (slv_modes[0] == $past(mst_modes[0])) && (slv_clk[NT-1] == $past(mst_clk[NT-1])))
    else $error("slaves not loaded on strobe");

  a_slave_hold: assert property ( // [RULE2]
    !xfer_stb && !g_tgt[0].rst_hit |=> $stable(slv_modes[0]) && $stable(slv_clk[0]))
    else $error("slave changed without transfer");

  a_sel_write: assert property ( // [RULE11]
    wr_clk && sel[0] |=> mst_clk[0] == ($past(reg_req.wdata) & cbr_pkg::CBR_CLK_MASK))
    else $error("enabled target missed write");

  a_unsel_hold: assert property ( // [RULE11]
    wr_clk && !sel[1] |=> $stable(mst_clk[1]))
    else $error("disabled target took write");

  a_index_now: assert property ( // [RULE3]
    wr_lo |=> losel_reg == $past(reg_req.wdata))
    else $error("index write not immediate");

  a_id_fixed: assert property ( // [RULE8]
    reg_req.rd && reg_req.addr == cbr_pkg::CBR_ADDR_ID |=> reg_rd_valid && reg_rdata == DIE_ID)
    else $error("identifier readback wrong");

  a_rst_return: assert property ( // [RULE20]
    g_tgt[0].rst_hit && !xfer_stb |=> !g_tgt[0].rst_hit && chip_reset_out[0])
    else $error("reset code not returned to run");

  a_ext_pd: assert property ( // [RULE15]
    HAS_PDWN_PIN && slv_modes[0][7] && !pdwn_pin_n && slv_modes[0][6:5] == 2'h0 |=> ctl_out[0].full_pd)
    else $error("pin power-down not applied");

  a_dcs_follow: assert property ( // [RULE23]
    1'b1 |=> ctl_out[0].duty_cycle_stabilizer == $past(slv_clk[0][0]))
    else $error("stabilizer enable mismatch");

endmodule

// [tb/cbr_host_model.sv]
// Host model that programs the register map one byte at a time
`timescale 1ns/100ps
module cbr_host_model (
  input wire logic clk_sys,
  output cbr_pkg::cbr_bus_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  // Bus idle from time zero
  initial begin
    reg_req = '0;
  end

  // One write strobe; address and data show inverted values once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One read strobe; answer is taken in the cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    @(posedge clk_sys);
    v = reg_rdata;
    ok = reg_rd_valid;
  endtask

  task automatic xfer_cmd();
    wr(8'hff, 8'h01);
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the buffered register map
`timescale 1ns/100ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %0h expected %0h", $time, (got), (exp)); end end
module tb_top;
  localparam logic [7:0] ID_VAL = 8'h5a; // Arbitrary value
  logic clk_sys;
  logic srst;
  logic xfer_pin;
  logic pdwn_pin_n;
  cbr_pkg::cbr_bus_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rd_valid;
  logic xfer_stb_out;
  logic [cbr_pkg::CBR_NT-1:0] chip_reset_out;
  cbr_pkg::cbr_ctl_t ctl_out [cbr_pkg::CBR_NT];
  cbr_pkg::cbr_ctl_t ctl_nopin [cbr_pkg::CBR_NT];
  int mismatches = 0;
  int n_checks = 0;
  int n_stb = 0;
  int n_crst = 0;
  int crst0;

  cbr_regmap #(.DIE_ID(ID_VAL)) DUT (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .xfer_pin(xfer_pin), .pdwn_pin_n(pdwn_pin_n), .xfer_stb_out(xfer_stb_out),
    .chip_reset_out(chip_reset_out), .ctl_out(ctl_out));

  cbr_host_model host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

  // Second copy built without power-down pin or hardware transfer, fed the same writes
  cbr_regmap #(.HAS_PDWN_PIN(1'b0), .HAS_HW_XFER(1'b0)) DUT_NOPIN (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req),
    .reg_rdata(), .reg_rd_valid(), .xfer_pin(xfer_pin), .pdwn_pin_n(pdwn_pin_n), .xfer_stb_out(), .chip_reset_out(),
    .ctl_out(ctl_nopin));

  // Clock at 50 ns
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Count strobes and chip reset pulses of target 0
  always @(posedge clk_sys) begin
    if (xfer_stb_out === 1'b1) n_stb++;
    if (chip_reset_out[0] === 1'b1) n_crst++;
  end

  // Power state of one target
  function automatic logic [3:0] pwr4(input int t);
    return {ctl_out[t].full_pd, ctl_out[t].standby, ctl_out[t].core_pd, ctl_out[t].afe_pd};
  endfunction

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    host.rd(a, v, ok);
    `CHK(ok, 1'b1)
    `CHK(v, exp)
  endtask

  // Counts strobes over a window long enough for a transfer to settle
  task automatic stb_chk(input int exp);
    int n0;
    n0 = n_stb;
    repeat (6) @(posedge clk_sys);
    `CHK(n_stb - n0, exp)
  endtask

  task automatic xfer();
    host.xfer_cmd();
    stb_chk(1);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    final_report();
  end

  initial begin
    srst = 1'b1;
    xfer_pin = 1'b0;
    pdwn_pin_n = 1'b0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    // Reset values, identifier and unmapped place
    rd_chk(8'h09, 8'h01);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h05, 8'h01);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'hff, 8'h00);
    rd_chk(8'h03, 8'h00);
    host.wr(8'h01, 8'ha5);
    rd_chk(8'h01, ID_VAL);
    `CHK(ctl_out[0].duty_cycle_stabilizer, 1'b1)
    $display("test reset done");
    // Multi-target write through both index registers
    host.wr(8'h05, 8'hfa);
    host.wr(8'h04, 8'h05);
    host.wr(8'h08, 8'h08);
    repeat (4) @(posedge clk_sys);
    `CHK(ctl_out[1].bypass, 1'b0)
    rd_chk(8'h08, 8'h08);
    xfer();
    for (int i = 0; i < 16; i++) `CHK(ctl_out[i].bypass, 16'h0f5a >> i & 1'b1)
    rd_chk(8'hff, 8'h00);
    $display("test index done");
    // Clock register through master and slave
    host.wr(8'h05, 8'h01);
    host.wr(8'h04, 8'h00);
    rd_chk(8'h05, 8'h01);
    host.wr(8'h09, 8'h06);
    rd_chk(8'h09, 8'h06);
    `CHK(ctl_out[0].pll_en, 1'b0)
    xfer();
    `CHK({ctl_out[0].pll_en, ctl_out[0].clk_boost, ctl_out[0].duty_cycle_stabilizer}, 3'b110)
    $display("test clock done");
    // Internal power codes with the pin low and external enable clear
    for (int c = 0; c < 8; c++) begin
      if (c == 3) continue;
      host.wr(8'h08, 8'(c));
      xfer();
      `CHK(pwr4(0), {c == 1, c == 2, c == 4, c == 5})
    end
    host.wr(8'h08, 8'h03);
    crst0 = n_crst;
    xfer();
    `CHK(n_crst - crst0, 1)
    rd_chk(8'h08, 8'h00);
    $display("test power done");
    // External pin modes, internal field set to standby
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h08, {1'b1, 2'(c), 5'h02});
      xfer();
      `CHK({pwr4(0), ctl_out[0].dout_en}, {c == 0, c == 1, 2'b00, c >= 2})
      `CHK({ctl_nopin[0].full_pd, ctl_nopin[0].standby, ctl_nopin[0].dout_en}, 3'b010)
      pdwn_pin_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK(pwr4(0), 4'h0)
      pdwn_pin_n <= 1'b0;
    end
    $display("test pin done");
    // Hardware transfer by pin
    host.wr(8'hff, 8'h80);
    rd_chk(8'hff, 8'h80);
    host.wr(8'h09, 8'h01);
    stb_chk(0);
    xfer_pin <= 1'b1;
    stb_chk(1);
    xfer_pin <= 1'b0;
    `CHK({ctl_out[0].pll_en, ctl_out[0].duty_cycle_stabilizer}, 2'b01)
    `CHK(ctl_nopin[0].pll_en, 1'b1)
    host.wr(8'hff, 8'h00);
    xfer_pin <= 1'b1;
    stb_chk(0);
    xfer_pin <= 1'b0;
    $display("test hardware transfer done");
    final_report();
  end
endmodule
